// ### src/bus_match_fifo.sv
// Bus-matching FIFO read port: long words in on port A, 36/18/9-bit pieces out on
// port B, flag recovery, mailboxes, and a Wishbone register window.
// Assumes port clocks are pins far slower than clk_i, sampled through synchronisers.
//
// What this block does
// RL1: Long-word mode passes all four lanes unchanged.
// RL2: Word mode: two reads, lane select picks half.
// RL3: Byte mode: four reads, lane select picks order.
// RL4: Word reads leave upper eighteen lines undefined.
// RL5: Byte reads leave upper lines undefined.
// RL6: Size pins static; lane order sampled at reset.
// RL7: Fall-through: valid and data within three cycles.
// RL8: Output valid drops only after last piece.
// RL9: Normal mode: empty flag rises next read edge.
// RL10: Fall-through: input ready rises next write edge.
// RL11: Normal mode: full flag rises next write edge.
// RL12: Full recovery timed from final piece read.
// RL13: Almost-full recovery timed from final piece read.
// RL14: Almost-full threshold uses whole memory depth.
// RL15: Word mode A-to-B mailbox uses low lines.
// RL16: Byte mode B-to-A mailbox uses low lines.
// RL17: Depth cascades tie both mailbox selects low.
// RL18: Cascade transfer clock is the faster clock.
// RL19: Memory read whole; remainder held in auxiliary.
// RL20: Lane order latched on first reset rising.
// RL21: Mailbox data bypasses lane ordering.
// RL22: Flags may be late, never early.
//
// Chosen here: the register addresses and register access over Wishbone.

`timescale 1ns/1ps

module bus_match_fifo
	import fifo_read_pkg::*;
#(
	parameter int DEPTH = DEFAULT_DEPTH
) (
	// System clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [WB_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Reset and configuration pins
	input  wire logic              first_reset_n_i,
	input  wire logic              lane_sequence_select_i,
	input  wire logic              fall_through_mode_i,
	input  wire logic              bus_match_select_i,
	input  wire logic              size_select_i,
	// Port A
	input  wire logic              side_a_clock_i,
	input  wire logic              a_enable_i,
	input  wire logic              a_write_i,
	input  wire logic              side_a_mailbox_select_i,
	input  wire logic [DATA_W-1:0] a_data_i,
	output logic      [DATA_W-1:0] a_data_o,
	output logic                   a_data_oe_o,
	output logic                   full_flag_n_o,
	output logic                   input_ready_o,
	output logic                   almost_full_n_o,
	output logic                   a_to_b_mail_n_o,
	// Port B
	input  wire logic              side_b_clock_i,
	input  wire logic              b_enable_i,
	input  wire logic              b_write_i,
	input  wire logic              side_b_mailbox_select_i,
	input  wire logic [DATA_W-1:0] b_data_i,
	output logic      [DATA_W-1:0] b_data_o,
	output logic                   b_data_oe_o,
	output logic                   empty_flag_n_o,
	output logic                   output_valid_o,
	output logic                   almost_empty_n_o,
	output logic                   b_to_a_mail_n_o
);

	// ==========================================================
	// Declarations
	localparam int ADDR_W = $clog2(DEPTH);
	localparam int PTR_W  = ADDR_W + 1;
	localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH); // Full memory depth

	pins_t             pin_raw;      // Pins gathered for synchronising
	pins_t             pin_s2;       // Second stage view
	pins_t             pin_s3;       // Third stage view, used as pin value
	logic              a_lvl;        // Agreed level of the port A clock
	logic              b_lvl;        // Agreed level of the port B clock
	logic              r1_lvl;       // Agreed level of the first reset
	logic              a_edge;       // Port A rising edge seen this cycle
	logic              b_edge;       // Port B rising edge seen this cycle
	logic              r1_edge;      // First reset released this cycle
	logic              lane_hi;      // Latched lane order, high half first
	logic              fall_through_mode;         // Latched fall-through mode
	logic              fifo_clear;   // Pointers held at zero
	bus_size_t         size_mode;    // Port B bus size from the pins
	logic [1:0]        last_idx;     // Index of the last piece of a word
	logic [31:0]       ctrl;         // Almost flag offsets
	logic [PTR_W-1:0]  wptr;         // Write pointer
	logic [PTR_W-1:0]  wptr_b1;      // Write pointer, one read edge late
	logic [PTR_W-1:0]  wptr_b2;      // Write pointer, two read edges late
	logic [PTR_W-1:0]  rptr;         // Next long word to load
	logic [PTR_W-1:0]  fptr;         // Next long word to free
	logic [PTR_W-1:0]  avail_ptr;    // Write pointer as seen by port B
	logic [1:0]        piece;        // Next piece within the current word
	logic [DATA_W-1:0] mem_q;        // Long word at rptr
	logic [DATA_W-1:0] aux;          // Remainder of the current word
	logic [DATA_W-1:0] fifo_out;     // FIFO output register
	logic              out_last;     // Output register holds a final piece
	logic [DATA_W-1:0] mail_ab;      // Mailbox from A to B
	logic [DATA_W-1:0] mail_ba;      // Mailbox from B to A
	logic              a_fifo_wr;    // Accepted FIFO write
	logic              b_fifo_rd;    // FIFO read request on port B
	logic              load;         // Piece moves into the output register
	logic              consume;      // Final piece leaves, word freed
	logic [PTR_W-1:0]  next_wptr;    // Write pointer after this cycle
	logic [PTR_W-1:0]  next_rptr;    // Load pointer after this cycle
	logic [PTR_W-1:0]  next_fptr;    // Free pointer after this cycle
	logic [PTR_W-1:0]  fill_a;       // Fill seen by port A flags
	logic [PTR_W-1:0]  fill_b;       // Fill seen by port B flags
	logic [PTR_W-1:0]  af_limit;     // Largest fill with almost-full high
	logic              wb_hit;       // Bus request waiting for an answer

	// ==========================================================
	// Helpers

	// Keep only the lines that the bus size makes usable
	function automatic logic [DATA_W-1:0] size_mask(input logic [DATA_W-1:0] d,
	                                                 input bus_size_t sz);
		logic [DATA_W-1:0] r;
		r = d;
		if (sz == SIZE_WORD) begin
			r = {{(DATA_W-HALF_W){1'b0}}, d[HALF_W-1:0]};
		end else if (sz == SIZE_BYTE) begin
			r = {{(DATA_W-LANE_W){1'b0}}, d[LANE_W-1:0]};
		end
		return r;
	endfunction

	// Pick one piece of a long word; undriven upper lines read as zero
	function automatic logic [DATA_W-1:0] pick(input logic [DATA_W-1:0] w,
	                                           input logic [1:0] idx,
	                                           input bus_size_t sz,
	                                           input logic hi_first);
		logic [DATA_W-1:0] r;
		logic [1:0]        lane;
		r    = w;                                                  // RL1
		lane = hi_first ? 2'(3 - idx) : idx;
		if (sz == SIZE_WORD) begin
			if ((idx == 2'h0) == hi_first) begin                  // RL2
				r = {{(DATA_W-HALF_W){1'b0}}, w[DATA_W-1:HALF_W]};  // RL4
			end else begin
				r = {{(DATA_W-HALF_W){1'b0}}, w[HALF_W-1:0]};
			end
		end else if (sz == SIZE_BYTE) begin
			r = {{(DATA_W-LANE_W){1'b0}}, w[lane*LANE_W +: LANE_W]}; // RL3 RL5
		end
		return r;
	endfunction

	// ==========================================================
	// Pin synchronisers and port clock edges
	always_comb begin
		pin_raw.a_clk   = side_a_clock_i;
		pin_raw.b_clk   = side_b_clock_i;
		pin_raw.rst1_n  = first_reset_n_i;
		pin_raw.lane_hi = lane_sequence_select_i;
		pin_raw.fall_through_mode    = fall_through_mode_i;
		pin_raw.bm      = bus_match_select_i;
		pin_raw.size    = size_select_i;
		pin_raw.a_en    = a_enable_i;
		pin_raw.a_wr    = a_write_i;
		pin_raw.a_mbx   = side_a_mailbox_select_i;
		pin_raw.a_data  = a_data_i;
		pin_raw.b_en    = b_enable_i;
		pin_raw.b_wr    = b_write_i;
		pin_raw.b_mbx   = side_b_mailbox_select_i;
		pin_raw.b_data  = b_data_i;
	end

	pin_sync #(
		.W ($bits(pins_t))
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (pin_raw),
		.s2_o  (pin_s2),
		.s3_o  (pin_s3)
	);

	// A change counts once stages two and three agree
	assign a_edge  = (pin_s2.a_clk == pin_s3.a_clk) && pin_s3.a_clk && !a_lvl;
	assign b_edge  = (pin_s2.b_clk == pin_s3.b_clk) && pin_s3.b_clk && !b_lvl;
	assign r1_edge = (pin_s2.rst1_n == pin_s3.rst1_n) && pin_s3.rst1_n && !r1_lvl;

	// Agreed levels; clocks reset high, but zeroed stages agree low first, so a high pin at reset still makes an edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_lvl  <= 1'b1;
			b_lvl  <= 1'b1;
			r1_lvl <= 1'b0;
		end else begin
			if (pin_s2.a_clk == pin_s3.a_clk) a_lvl <= pin_s3.a_clk;
			if (pin_s2.b_clk == pin_s3.b_clk) b_lvl <= pin_s3.b_clk;
			if (pin_s2.rst1_n == pin_s3.rst1_n) r1_lvl <= pin_s3.rst1_n;
		end
	end

	// ==========================================================
	// Configuration
	// Lane order and fall-through latched as the first reset releases
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lane_hi <= 1'b0;
			fall_through_mode    <= 1'b0;
		end else if (r1_edge) begin
			lane_hi <= pin_s3.lane_hi; // RL20 RL6
			fall_through_mode    <= pin_s3.fall_through_mode;
		end
	end

	// Size pins are static, so they are used as they stand
	always_comb begin
		if (!pin_s3.bm) begin
			size_mode = SIZE_LONG;
			last_idx  = 2'h0;
		end else if (!pin_s3.size) begin
			size_mode = SIZE_WORD;
			last_idx  = 2'h1;
		end else begin
			size_mode = SIZE_BYTE;
			last_idx  = 2'h3;
		end
	end

	assign fifo_clear = rst_i || !r1_lvl;

	// ==========================================================
	// Transfer decode
	assign a_fifo_wr = a_edge && pin_s3.a_en && pin_s3.a_wr && !pin_s3.a_mbx
	                   && (fall_through_mode ? input_ready_o : full_flag_n_o);
	assign b_fifo_rd = b_edge && pin_s3.b_en && !pin_s3.b_wr && !pin_s3.b_mbx;
	// Fall-through sees writes two read edges late, so data lands on the third
	assign avail_ptr = fall_through_mode ? wptr_b2 : wptr; // RL7 RL22

	always_comb begin
		if (fall_through_mode) begin
			load    = b_edge && (avail_ptr != rptr) && (!output_valid_o || b_fifo_rd);
			consume = b_fifo_rd && output_valid_o && out_last; // RL12
		end else begin
			load    = b_fifo_rd && empty_flag_n_o;
			consume = load && (piece == last_idx); // RL12
		end
	end

	assign next_wptr = wptr + PTR_W'(a_fifo_wr);
	assign next_rptr = rptr + PTR_W'(load && (piece == last_idx));
	assign next_fptr = fptr + PTR_W'(consume);
	assign fill_a    = next_wptr - next_fptr;
	assign fill_b    = wptr - next_fptr;
	assign af_limit  = DEPTH_P - PTR_W'(ctrl[CTRL_AF_LSB +: CTRL_FIELD_W]) - PTR_W'(1); // RL14

	// ==========================================================
	// Storage
	word_ram #(
		.DATA_W (DATA_W),
		.ADDR_W (ADDR_W)
	) u_ram (
		.clk_i     (clk_i),
		.wr_en_i   (a_fifo_wr),
		.wr_addr_i (wptr[ADDR_W-1:0]),
		.wr_data_i (pin_s3.a_data),
		.rd_addr_i (rptr[ADDR_W-1:0]),
		.rd_data_o (mem_q)
	);

	// Write pointer
	always_ff @(posedge clk_i) begin
		if (fifo_clear) begin
			wptr <= '0;
		end else begin
			wptr <= next_wptr;
		end
	end

	// Delayed views of the write pointer, stepped by port B edges
	always_ff @(posedge clk_i) begin
		if (fifo_clear) begin
			wptr_b1 <= '0;
			wptr_b2 <= '0;
		end else if (b_edge) begin
			wptr_b1 <= wptr;
			wptr_b2 <= wptr_b1;
		end
	end

	// ==========================================================
	// Read side: piece sequencing
	always_ff @(posedge clk_i) begin
		if (fifo_clear) begin
			rptr     <= '0;
			fptr     <= '0;
			piece    <= 2'h0;
			aux      <= '0;
			fifo_out <= '0;
			out_last <= 1'b0;
		end else begin
			rptr <= next_rptr;
			fptr <= next_fptr;
			if (load) begin
				// Whole word read once; the rest waits in the auxiliary register
				if (piece == 2'h0) begin
					aux      <= mem_q; // RL19
					fifo_out <= pick(mem_q, piece, size_mode, lane_hi);
				end else begin
					fifo_out <= pick(aux, piece, size_mode, lane_hi);
				end
				out_last <= (piece == last_idx);
				piece    <= (piece == last_idx) ? 2'h0 : piece + 2'h1;
			end
		end
	end

	// Read side flags, updated on port B edges
	always_ff @(posedge clk_i) begin
		if (fifo_clear) begin
			empty_flag_n_o   <= 1'b0;
			output_valid_o   <= 1'b0;
			almost_empty_n_o <= 1'b0;
		end else if (b_edge) begin
			empty_flag_n_o <= !fall_through_mode && (avail_ptr != next_rptr); // RL9
			if (!fall_through_mode) begin
				output_valid_o <= 1'b0;
			end else if (load) begin
				output_valid_o <= 1'b1;                          // RL7
			end else if (b_fifo_rd && output_valid_o) begin
				output_valid_o <= 1'b0;                          // RL8
			end
			almost_empty_n_o <= fill_b > PTR_W'(ctrl[CTRL_AE_LSB +: CTRL_FIELD_W]);
		end
	end

	// Write side flags, updated on port A edges from the freed pointer
	always_ff @(posedge clk_i) begin
		if (fifo_clear) begin
			full_flag_n_o   <= 1'b0;
			input_ready_o   <= 1'b0;
			almost_full_n_o <= 1'b0;
		end else if (a_edge) begin
			full_flag_n_o   <= !fall_through_mode && (fill_a != DEPTH_P); // RL11 RL12
			input_ready_o   <= fall_through_mode && (fill_a != DEPTH_P);  // RL10 RL12
			almost_full_n_o <= fill_a <= af_limit;           // RL13
		end
	end

	// ==========================================================
	// Mailboxes, width limited by bus size, never lane ordered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mail_ab         <= '0;
			a_to_b_mail_n_o <= 1'b1;
		end else begin
			if (a_edge && pin_s3.a_en && pin_s3.a_wr && pin_s3.a_mbx && a_to_b_mail_n_o) begin
				mail_ab         <= size_mask(pin_s3.a_data, size_mode); // RL15 RL21
				a_to_b_mail_n_o <= 1'b0;
			end else if (b_edge && pin_s3.b_en && !pin_s3.b_wr && pin_s3.b_mbx) begin
				a_to_b_mail_n_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mail_ba         <= '0;
			b_to_a_mail_n_o <= 1'b1;
		end else begin
			if (b_edge && pin_s3.b_en && pin_s3.b_wr && pin_s3.b_mbx && b_to_a_mail_n_o) begin
				mail_ba         <= size_mask(pin_s3.b_data, size_mode); // RL16 RL21
				b_to_a_mail_n_o <= 1'b0;
			end else if (a_edge && pin_s3.a_en && !pin_s3.a_wr && pin_s3.a_mbx) begin
				b_to_a_mail_n_o <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Port data outputs: port B mailbox select steers the source; port A always shows mail_ba
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_data_o    <= '0;
			a_data_oe_o <= 1'b0;
			b_data_o    <= '0;
			b_data_oe_o <= 1'b0;
		end else begin
			a_data_o    <= mail_ba;
			a_data_oe_o <= pin_s3.a_en && !pin_s3.a_wr && pin_s3.a_mbx;
			b_data_o    <= pin_s3.b_mbx ? mail_ab : fifo_out;
			b_data_oe_o <= pin_s3.b_en && !pin_s3.b_wr;
		end
	end

	// ==========================================================
	// Wishbone slave: ack one cycle after the request, dropped the next
	assign wb_hit = wb_cyc_i && wb_stb_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_hit && !wb_ack_o;
			unique case (wb_adr_i)
				REG_CTRL:   wb_dat_o <= ctrl;
				REG_STATUS: wb_dat_o <= {20'h0, size_mode, lane_hi, fall_through_mode,
				                         b_to_a_mail_n_o, a_to_b_mail_n_o,
				                         almost_full_n_o, almost_empty_n_o,
				                         input_ready_o, full_flag_n_o,
				                         output_valid_o, empty_flag_n_o};
				REG_LEVEL:  wb_dat_o <= 32'(wptr - fptr);
				default:    wb_dat_o <= '0;
			endcase
		end
	end

	// Control writes take effect on the edge that sees ack high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= CTRL_RESET;
		end else if (wb_hit && wb_we_i && wb_ack_o && (wb_adr_i == REG_CTRL)) begin
			for (int i = 0; i < 4; i++) begin
				if (wb_sel_i[i]) ctrl[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
			end
		end
	end

endmodule

// ### src/fifo_read_pkg.sv
// Shared constants, types and pin bundles for the bus-matching FIFO read port.
// Assumes one system clock; port clocks arrive as ordinary pins.

package fifo_read_pkg;

	// ==========================================================
	// Data path geometry
	localparam int DATA_W        = 36;   // Long word width
	localparam int HALF_W        = 18;   // Word bus width
	localparam int LANE_W        = 9;    // Byte bus width
	localparam int DEFAULT_DEPTH = 1024; // Long words of storage
	localparam int SYNC_STAGES   = 3;    // Flip-flops on every pin input

	// ==========================================================
	// Wishbone register map (byte addresses)
	localparam int          WB_ADR_W   = 8;
	localparam logic [7:0]  REG_CTRL   = 8'h00; // Almost flag offsets
	localparam logic [7:0]  REG_STATUS = 8'h04; // Flag and mode view
	localparam logic [7:0]  REG_LEVEL  = 8'h08; // Stored long words

	// Control register fields and reset value
	localparam int          CTRL_AE_LSB   = 0;
	localparam int          CTRL_AF_LSB   = 16;
	localparam int          CTRL_FIELD_W  = 16;
	localparam logic [31:0] CTRL_RESET    = 32'h0008_0008;

	// Status register bit positions
	localparam int ST_EMPTY_N   = 0;
	localparam int ST_OUT_VALID = 1;
	localparam int ST_FULL_N    = 2;
	localparam int ST_IN_READY  = 3;
	localparam int ST_AE_N      = 4;
	localparam int ST_AF_N      = 5;
	localparam int ST_MAIL_AB_N = 6;
	localparam int ST_MAIL_BA_N = 7;
	localparam int ST_FALL_THROUGH_MODE      = 8;
	localparam int ST_LANE_HI   = 9;
	localparam int ST_SIZE_LSB  = 10;

	// ==========================================================
	// Port B bus size
	typedef enum logic [1:0] {
		SIZE_LONG,
		SIZE_WORD,
		SIZE_BYTE
	} bus_size_t;

	// Every pin that crosses into the system clock domain
	typedef struct packed {
		logic              a_clk;
		logic              b_clk;
		logic              rst1_n;
		logic              lane_hi;
		logic              fall_through_mode;
		logic              bm;
		logic              size;
		logic              a_en;
		logic              a_wr;
		logic              a_mbx;
		logic [DATA_W-1:0] a_data;
		logic              b_en;
		logic              b_wr;
		logic              b_mbx;
		logic [DATA_W-1:0] b_data;
	} pins_t;

endpackage

// ### src/pin_sync.sv
// Three-stage synchroniser for a bundle of asynchronous pins.
// Assumes the caller reads only the second and third stages.

`timescale 1ns/1ps

module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Pins and synchronised views
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] s2_o,
	output logic      [W-1:0] s3_o
);

	logic [W-1:0] s1; // First stage, read by the second only

	// ==========================================================
	// Shift chain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1   <= '0;
			s2_o <= '0;
			s3_o <= '0;
		end else begin
			s1   <= d_i;
			s2_o <= s1;
			s3_o <= s2_o;
		end
	end

endmodule

// ### src/word_ram.sv
// Simple dual-port storage for long words, registered read data.
// Assumes a read address is stable one cycle before its data is used.

`timescale 1ns/1ps

module word_ram #(
	parameter int DATA_W = 36,
	parameter int ADDR_W = 10
) (
	// Clock
	input  wire logic              clk_i,
	// Write side
	input  wire logic              wr_en_i,
	input  wire logic [ADDR_W-1:0] wr_addr_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	// Read side
	input  wire logic [ADDR_W-1:0] rd_addr_i,
	output logic      [DATA_W-1:0] rd_data_o
);

	logic [DATA_W-1:0] mem [2**ADDR_W]; // Storage array

	// ==========================================================
	// Write port
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	// Read port, data from a register
	always_ff @(posedge clk_i) begin
		rd_data_o <= mem[rd_addr_i];
	end

endmodule

// ### bench/fifo_read_chk.sv
// Checker on the FIFO read port pins: bus handshake and flag relations.
// Assumes it is bound to bus_match_fifo; every watched pin is in clk_i.
`timescale 1ns/1ps
module fifo_read_chk
	import fifo_read_pkg::*;
(
	// Clock, reset and watched pins
	input wire logic                wb_ack_o, wb_cyc_i, wb_stb_i, wb_we_i, clk_i, rst_i,
	input wire logic [WB_ADR_W-1:0] wb_adr_i,
	input wire logic [31:0]         wb_dat_o,
	input wire logic                bus_match_select_i, size_select_i, first_reset_n_i,
	input wire logic                empty_flag_n_o, output_valid_o, full_flag_n_o, input_ready_o
);
	// ==========================================================
	// Size code expected in the status view
	logic [1:0] size_code;
	assign size_code = !bus_match_select_i ? 2'h0 : (size_select_i ? 2'h2 : 2'h1);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held over one cycle");
	a_ack_has_request: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack without request");
	a_ack_in_cycle: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
		else $error("ack outside a cycle");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h08 |-> wb_dat_o == 0)
		else $error("unmapped read not zero");
	a_status_size: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == REG_STATUS |-> wb_dat_o[11:10] == size_code)
		else $error("size field wrong");
	a_empty_mode_excl: assert property (!(empty_flag_n_o && output_valid_o))
		else $error("both read flags high");
	a_full_mode_excl: assert property (!(full_flag_n_o && input_ready_o))
		else $error("both write flags high");
	a_reset_clears: assert property (
		!first_reset_n_i [*6] |-> !empty_flag_n_o && !full_flag_n_o)
		else $error("flags up in reset");
	cover property ($fell(empty_flag_n_o));
	cover property ($fell(full_flag_n_o));
	cover property ($rose(wb_ack_o) && wb_we_i);
endmodule
bind bus_match_fifo fifo_read_chk chk_u (.*);

// ### bench/port_clock_model.sv
// Far-side logic model: free-running clocks of both FIFO ports.
// Assumes the bench drives port controls between these clock edges.
`timescale 1ns/1ps
module port_clock_model (
	// System clock
	input  wire logic clk_i,
	// Port clocks, unrelated periods
	output logic      side_a_clock_o,
	output logic      side_b_clock_o
);
	logic [3:0] a_cnt = 4'h0; // Side A half-period count
	logic [3:0] b_cnt = 4'h3; // Side B count, offset phase
	initial side_a_clock_o = 1'b0;
	initial side_b_clock_o = 1'b0;
	// Side A holds each level eight cycles
	always_ff @(posedge clk_i) begin
		a_cnt <= (a_cnt == 4'h7) ? 4'h0 : a_cnt + 4'h1;
		if (a_cnt == 4'h7) side_a_clock_o <= !side_a_clock_o;
	end
	// Side B holds each level nine cycles
	always_ff @(posedge clk_i) begin
		b_cnt <= (b_cnt == 4'h8) ? 4'h0 : b_cnt + 4'h1;
		if (b_cnt == 4'h8) side_b_clock_o <= !side_b_clock_o;
	end
endmodule

// ### bench/tb_top.sv
// Testbench for the FIFO read port: bus sizing, lane order, flags, mailbox.
// Assumes port clocks from port_clock_model and a 16-word FIFO.
`timescale 1ns/1ps
module tb_top
	import fifo_read_pkg::*;
;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        first_reset_n_i, lane_sequence_select_i, fall_through_mode_i;
	logic        bus_match_select_i, size_select_i, side_a_clock_i, side_b_clock_i;
	logic        a_enable_i, a_write_i, side_a_mailbox_select_i, a_data_oe_o;
	logic        full_flag_n_o, input_ready_o, almost_full_n_o, a_to_b_mail_n_o;
	logic        b_enable_i, b_write_i, side_b_mailbox_select_i, b_data_oe_o;
	logic        empty_flag_n_o, output_valid_o, almost_empty_n_o, b_to_a_mail_n_o;
	logic [35:0] a_data_i, a_data_o, b_data_i, b_data_o;
	int          failures, compares;
	wire  [4:0]  watch = {full_flag_n_o, empty_flag_n_o, wb_ack_o, side_b_clock_i, side_a_clock_i};
	localparam logic [35:0] long_word = {9'h1a5, 9'h0c3, 9'h13c, 9'h05a};
	logic [2:0]  modes [5] = '{3'b001, 3'b101, 3'b100, 3'b111, 3'b110}; // bm, size, lane
	bus_match_fifo #(.DEPTH(16)) dut_u (.*);
	port_clock_model clk_model_u (.clk_i(clk_i), .side_a_clock_o(side_a_clock_i),
		.side_b_clock_o(side_b_clock_i));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// ==========================================================
	// Verdict, comparison and bounded waits
	task automatic tally_and_finish();
		if (failures == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Waits for watched bit k to be sampled at lvl; a timeout fails the run
	task automatic wait_for(input int k, input logic lvl);
		int n;
		for (n = 0; n < 4000; n++) begin
			@(posedge clk_i);
			if (watch[k] === lvl) return;
		end
		failures++;
		tally_and_finish();
	endtask
	// One classic bus cycle, held until ack
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, d};
		wait_for(2, 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	// One port access (k 0 is side A write, 1 is side B read), set up a half period early
	task automatic port_op(input int k, input logic mbx, input logic [35:0] d,
		output logic [35:0] rd);
		wait_for(k, 1'b1);
		wait_for(k, 1'b0);
		if (k == 0) {a_enable_i, side_a_mailbox_select_i, a_data_i} <= {1'b1, mbx, d};
		else {b_enable_i, side_b_mailbox_select_i} <= {1'b1, mbx};
		wait_for(k, 1'b1);
		wait_for(k, 1'b0);
		rd = b_data_o;
		{a_enable_i, b_enable_i} <= 2'b00;
	endtask
	// Full reset with straps held static until the next one
	task automatic restart(input logic [2:0] cfg);
		@(posedge clk_i);
		{rst_i, first_reset_n_i} <= 2'b10;
		{bus_match_select_i, size_select_i, lane_sequence_select_i} <= cfg;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		first_reset_n_i <= 1'b1;
		wait_for(4, 1'b1);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		logic [35:0] rd, mask, expv;
		logic [31:0] rd32;
		int          n, w;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {11'h0, 4'hf, 32'h0};
		{rst_i, first_reset_n_i, lane_sequence_select_i, fall_through_mode_i} = 4'b1000;
		{bus_match_select_i, size_select_i, a_enable_i, a_write_i} = 4'b0001;
		{side_a_mailbox_select_i, b_enable_i, b_write_i, side_b_mailbox_select_i} = 4'h0;
		{a_data_i, b_data_i} = 72'h0;
		{failures, compares} = 64'h0;
		restart(3'b000);
		wb_xfer(1'b0, REG_CTRL, 32'h0, rd32);
		check({4'h0, rd32}, {4'h0, CTRL_RESET});
		wb_xfer(1'b1, REG_CTRL, 32'h0004_000c, rd32);
		wb_xfer(1'b0, REG_CTRL, 32'h0, rd32);
		check({4'h0, rd32}, 36'h4_000c);
		wb_xfer(1'b0, 8'hfc, 32'h0, rd32);
		check({4'h0, rd32}, 36'h0);
		// Each size, both lane orders in word and byte mode: one long word out in pieces
		foreach (modes[m]) begin
			restart(modes[m]);
			wb_xfer(1'b0, REG_STATUS, 32'h0, rd32);
			n = modes[m][2] ? (modes[m][1] ? 4 : 2) : 1;
			w = 36 / n;
			mask = (36'h1 << w) - 36'h1;
			port_op(0, 1'b0, long_word, rd);
			wait_for(3, 1'b1);
			for (int i = 0; i < n; i++) begin
				port_op(1, 1'b0, 36'h0, rd);
				expv = modes[m][0] ? long_word >> (36 - (i + 1) * w) : long_word >> (i * w);
				check(rd & mask, expv & mask);
				check({35'h0, empty_flag_n_o}, {35'h0, i < n - 1});
			end
		end
		// Word-mode mailbox uses the low lines, unordered
		restart(3'b101);
		port_op(0, 1'b1, 36'h9_8765_4321, rd);
		check({35'h0, a_to_b_mail_n_o}, 36'h0);
		port_op(1, 1'b1, 36'h0, rd);
		check(rd & 36'h3_ffff, 36'h1_4321);
		// Fill to the brim in byte mode, then free one long word
		restart(3'b110);
		for (int i = 0; i < 17; i++) begin
			port_op(0, 1'b0, 36'(i), rd);
			if (i == 6) check({35'h0, almost_full_n_o}, 36'h1);
			if (i == 8) check({35'h0, almost_full_n_o}, 36'h0);
		end
		check({35'h0, full_flag_n_o}, 36'h0);
		check({35'h0, input_ready_o}, 36'h0);
		check({35'h0, almost_empty_n_o}, 36'h1);
		for (int i = 0; i < 3; i++) port_op(1, 1'b0, 36'h0, rd);
		check({35'h0, full_flag_n_o}, 36'h0);
		port_op(1, 1'b0, 36'h0, rd);
		wait_for(4, 1'b1);
		check({35'h0, almost_full_n_o}, 36'h0);
		tally_and_finish();
	end
endmodule
